// ---- dasi_regs.svh ----
// Purpose: constants for the disc address intake and seek status block
// Assumes: 100 MHz ref_clk_i
// Notes: field widths follow the default address layout
`ifndef DASI_REGS_SVH
`define DASI_REGS_SVH
`define DASI_REC_W 8
`define DASI_POS_W 6
`define DASI_DISC_W 5
`define DASI_CHAN_W 4
`define DASI_ADDR_W 26
`define DASI_FH_GROUPS 12
`define DASI_CLK_MHZ 100
`define DASI_STROBE_DLY_NS 500
`define DASI_STROBE_DLY_CYC ((`DASI_STROBE_DLY_NS * `DASI_CLK_MHZ + 999) / 1000)
`define DASI_STROBE_GAP_CYC 4
`define DASI_WRONG_CMD_NS 5000
`define DASI_WRONG_CMD_CYC ((`DASI_WRONG_CMD_NS * `DASI_CLK_MHZ) / 1000)
`define DASI_WINDOW_CYC 64
`endif

// ---- dasi_pkg.sv ----
// Purpose: types for the disc address intake block
// Assumes: none
// Notes: state codes written out
package dasi_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DECIDE = 3'b011,
    ST_ANSWER = 3'b100,
    ST_VERIFIED = 3'b101,
    ST_XFER = 3'b110,
    ST_WINDOW = 3'b111
  } dasi_state_type;
endpackage

// ---- dasi_top.sv ----
// Purpose: serial address intake, decode and seek/transfer status signalling
// Assumes: pins pass two flip-flops; disc-side status arrives as levels and pulses
// Notes: all outputs registered
`timescale 1ns/10ps
`include "dasi_regs.svh"
module dasi_top #(
  parameter int REC_BITS = `DASI_REC_W,
  parameter bit FIXED_HEAD_OPT = 1'b1,
  parameter bit WIDE_CHAN_OPT = 1'b1,
  parameter bit ZONED_HEADS = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic connect_i,
  input wire logic write_data_i,
  input wire logic area_conflict_i,
  input wire logic held_elsewhere_i,
  input wire logic track_confirmed_i,
  input wire logic sector_before_i,
  input wire logic header_end_i,
  input wire logic record_end_i,
  input wire logic prelude_i,
  input wire logic stop_i,
  output logic bit_strobe_o,
  output logic seek_accepted_o,
  output logic area_conflict_o,
  output logic track_verified_o,
  output logic sector_approach_o,
  output logic channel_held_o,
  output logic header_area_done_o,
  output logic record_area_done_o,
  output logic wrong_command_o,
  output logic parity_error_o,
  output logic improper_address_o,
  output logic seek_start_o,
  output logic first_avail_o,
  output logic fixed_head_o,
  output logic [2:0] head_sel_o,
  output logic [7:0] sector_o,
  output logic [`DASI_POS_W-1:0] position_o,
  output logic [`DASI_DISC_W-1:0] disc_o,
  output logic [`DASI_CHAN_W-1:0] channel_o,
  output dasi_pkg::dasi_state_type state_o
);
  import dasi_pkg::*;

  // ----------------------------------------
  // Constants and helpers
  // ----------------------------------------
  localparam int FH_W = FIXED_HEAD_OPT ? 1 : 0;
  localparam int CH_W = WIDE_CHAN_OPT ? `DASI_CHAN_W : 2;
  localparam int LEN = 1 + FH_W + REC_BITS + `DASI_POS_W + `DASI_DISC_W + CH_W + 1;
  localparam logic [5:0] LEN6 = 6'(LEN);
  localparam logic [11:0] STROBE_DLY = 12'(`DASI_STROBE_DLY_CYC);
  localparam logic [11:0] GAP = 12'(`DASI_STROBE_GAP_CYC);
  localparam logic [11:0] WIN = 12'(`DASI_WINDOW_CYC);

  // Field extraction from the assembled word, low bits first
  function automatic logic [7:0] field_of(input logic [`DASI_ADDR_W-1:0] w,
                                          input int lsb, input int width);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i < width && lsb + i < `DASI_ADDR_W) begin
        r[i] = w[lsb+i];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [9:0] meta;
  logic [9:0] sync;
  logic connect_d;
  // Only the second stage is read; the first may still be settling
  always_ff @(posedge ref_clk_i) begin
    meta <= {stop_i, prelude_i, record_end_i, header_end_i, sector_before_i,
             track_confirmed_i, held_elsewhere_i, area_conflict_i, write_data_i,
             connect_i};
    sync <= meta;
    connect_d <= sync[0];
  end
  wire connect_p = sync[0] & ~connect_d;
  wire wdata = sync[1];
  wire conflict_s = sync[2];
  wire held_s = sync[3];
  wire confirmed_s = sync[4];
  wire before_s = sync[5];
  wire hdr_end_s = sync[6];
  wire rec_end_s = sync[7];
  wire prelude_s = sync[8];
  wire stop_s = sync[9];

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  dasi_state_type state;
  logic [11:0] tmr;
  logic [5:0] bit_cnt;
  logic [`DASI_ADDR_W-1:0] addr;
  logic strobe;
  // A connect is only taken once the previous address has been answered
  wire connect_ok = connect_p && (state == ST_IDLE || state >= ST_ANSWER);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      tmr <= 12'h000;
      bit_cnt <= 6'h00;
      addr <= '0;
      strobe <= 1'b0;
    end else begin
      strobe <= 1'b0;
      unique case (state)
        ST_WAIT: begin
          if (tmr >= STROBE_DLY) begin
            strobe <= 1'b1;
            tmr <= 12'h000;
            state <= ST_SHIFT;
          end else begin
            tmr <= tmr + 12'h001;
          end
        end
        ST_SHIFT: begin
          // Sample one gap after each strobe; host drives bit on strobe
          // Host gets one cycle from strobe to pin; a slower host needs a wider gap
          if (tmr == GAP) begin
            addr[bit_cnt[4:0]] <= wdata;
            tmr <= 12'h000;
            if (bit_cnt == LEN6 - 6'h01) begin
              state <= ST_DECIDE;
            end else begin
              bit_cnt <= bit_cnt + 6'h01;
              strobe <= 1'b1;
            end
          end else begin
            tmr <= tmr + 12'h001;
          end
        end
        ST_DECIDE: begin
          state <= ST_ANSWER;
        end
        ST_ANSWER: begin
          // Leave for the verified state once an accepted seek is confirmed
          if (seek_accepted_o && confirmed_s) begin
            state <= ST_VERIFIED;
          end
        end
        ST_VERIFIED: begin
          if (prelude_s) begin
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (rec_end_s) begin
            tmr <= 12'h000;
            state <= ST_WINDOW;
          end
        end
        ST_WINDOW: begin
          // Host stop or the time limit closes the window
          if (stop_s || tmr == WIN) begin
            state <= ST_VERIFIED;
          end else if (prelude_s) begin
            state <= ST_XFER;
          end else begin
            tmr <= tmr + 12'h001;
          end
        end
        ST_IDLE: ;
      endcase
      // New connect restarts intake unless an address is still unanswered
      if (connect_ok) begin
        state <= ST_WAIT;
        tmr <= 12'h000;
        bit_cnt <= 6'h00;
        addr <= '0;
      end
    end
  end
  assign state_o = state;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  localparam int P_REC = 1 + FH_W;
  localparam int P_POS = P_REC + REC_BITS;
  localparam int P_DISC = P_POS + `DASI_POS_W;
  localparam int P_CH = P_DISC + `DASI_DISC_W;
  wire fa_bit = addr[0];
  wire fh_bit = FIXED_HEAD_OPT ? addr[1] : 1'b0;
  wire [7:0] rec = field_of(addr, P_REC, REC_BITS);
  wire [7:0] pos8 = field_of(addr, P_POS, `DASI_POS_W);
  wire [7:0] disc8 = field_of(addr, P_DISC, `DASI_DISC_W);
  wire [7:0] ch8 = field_of(addr, P_CH, CH_W);
  wire par_ok = ^addr;
  // Group limit covers the whole position field, not only its low bits
  wire fh_bad = fh_bit && (pos8[5:0] > 6'h0B);
  // Head order: alternate outer/inner, or four outer then four inner
  wire [2:0] head = ZONED_HEADS ? rec[2:0] : {rec[0], rec[2:1]};

  // Decoded fields hold until the next address reaches the decide state
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      first_avail_o <= 1'b0;
      fixed_head_o <= 1'b0;
      head_sel_o <= 3'h0;
      sector_o <= 8'h00;
      position_o <= '0;
      disc_o <= '0;
      channel_o <= '0;
      seek_start_o <= 1'b0;
    end else begin
      seek_start_o <= 1'b0;
      if (state == ST_DECIDE) begin
        first_avail_o <= fa_bit;
        fixed_head_o <= fh_bit;
        // First-available only drops the sector: head, position, disc and channel kept
        head_sel_o <= head;
        sector_o <= fa_bit ? 8'h00 : {3'h0, rec[7:3]};
        position_o <= fh_bit ? {2'h0, pos8[3:0]} : pos8[5:0];
        disc_o <= disc8[4:0];
        channel_o <= ch8[3:0];
        seek_start_o <= par_ok && !fh_bad;
      end
    end
  end

  // ----------------------------------------
  // Answers to the host
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      seek_accepted_o <= 1'b0;
      area_conflict_o <= 1'b0;
      channel_held_o <= 1'b0;
      parity_error_o <= 1'b0;
      improper_address_o <= 1'b0;
      track_verified_o <= 1'b0;
    end else if (connect_ok) begin
      seek_accepted_o <= 1'b0;
      area_conflict_o <= 1'b0;
      channel_held_o <= 1'b0;
      parity_error_o <= 1'b0;
      improper_address_o <= 1'b0;
      track_verified_o <= 1'b0;
    end else if (state == ST_DECIDE) begin
      parity_error_o <= !par_ok;
      improper_address_o <= par_ok && fh_bad;
      if (par_ok && !fh_bad) begin
        channel_held_o <= held_s;
        area_conflict_o <= !held_s && conflict_s;
        seek_accepted_o <= !held_s && !conflict_s;
      end
    end else begin
      // Busy turns into accepted once the other channel lets the area go
      if (area_conflict_o && !conflict_s) begin
        area_conflict_o <= 1'b0;
        seek_accepted_o <= 1'b1;
      end
      if (state >= ST_ANSWER && seek_accepted_o && confirmed_s) begin
        track_verified_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Out-of-sequence connect
  // ----------------------------------------
  // Flag within four cycles; the second address is never taken
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wrong_command_o <= 1'b0;
    end else begin
      if (connect_p && !connect_ok) begin
        wrong_command_o <= 1'b1;
      end else if (connect_ok) begin
        wrong_command_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transfer framing
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      bit_strobe_o <= 1'b0;
      sector_approach_o <= 1'b0;
      header_area_done_o <= 1'b0;
      record_area_done_o <= 1'b0;
    end else begin
      bit_strobe_o <= strobe;
      // A taken connect drops verified at this edge, so approach drops too
      sector_approach_o <= (state == ST_VERIFIED || state == ST_WINDOW) && !connect_ok
                           && track_verified_o && before_s;
      // Done notices only count while a transfer is open
      header_area_done_o <= (state == ST_XFER) && hdr_end_s;
      record_area_done_o <= (state == ST_XFER) && rec_end_s;
    end
  end
endmodule

// ---- dasi_properties.sv ----
// Purpose: port-level checks for the disc address intake block
// Assumes: bound onto dasi_top, one clock domain
// Notes: answer latencies as handed over by the designer
`timescale 1ns/10ps
module dasi_properties
  import dasi_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic connect_i,
  input wire logic bit_strobe_o,
  input wire logic seek_accepted_o,
  input wire logic area_conflict_o,
  input wire logic channel_held_o,
  input wire logic parity_error_o,
  input wire logic improper_address_o,
  input wire logic track_verified_o,
  input wire logic sector_approach_o,
  input wire logic wrong_command_o,
  input wire dasi_pkg::dasi_state_type state_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  strobe_pulse_a: assert property (bit_strobe_o |=> !bit_strobe_o [*4])
    else $error("bit strobe too long or too close");
  // Earliest strobe 25 cycles, latest 800 cycles after connect
  strobe_delay_a: assert property ($rose(connect_i) && state_o == ST_IDLE |=>
    !bit_strobe_o [*8] ##[17:792] bit_strobe_o) else $error("first strobe out of range");
  wrong_connect_a: assert property ($rose(connect_i) && state_o == ST_WAIT |->
    ##[1:500] wrong_command_o) else $error("no wrong command flag");
  accept_conflict_a: assert property (!(seek_accepted_o && area_conflict_o))
    else $error("accepted and conflict together");
  accept_held_a: assert property (!(seek_accepted_o && channel_held_o))
    else $error("accepted and held together");
  parity_block_a: assert property (parity_error_o |-> !seek_accepted_o)
    else $error("accepted despite parity error");
  improper_block_a: assert property (improper_address_o |-> !seek_accepted_o)
    else $error("accepted despite improper address");
  approach_verified_a: assert property (sector_approach_o |-> track_verified_o)
    else $error("approach outside verified state");
  cover property ($rose(seek_accepted_o));
  cover property ($rose(wrong_command_o));
  cover property ($rose(sector_approach_o));
endmodule
bind dasi_top dasi_properties i_props (.ref_clk_i, .sys_rst_i, .connect_i, .bit_strobe_o,
  .seek_accepted_o, .area_conflict_o, .channel_held_o, .parity_error_o, .improper_address_o,
  .track_verified_o, .sector_approach_o, .wrong_command_o, .state_o);

// ---- dasi_host_model.sv ----
// Purpose: host channel model sending a serial address on bit strobes
// Assumes: strobes are one-cycle pulses
// Notes: a repeat start while busy only re-pulses connect
`timescale 1ns/10ps
module dasi_host_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [25:0] addr_i,
  input wire logic bit_strobe_i,
  output logic connect_o = 1'b0,
  output logic write_data_o = 1'b0,
  output int bits_o = 0
);
  logic busy = 1'b0;
  int pulse = 0;
  int hold = 0;
  always @(posedge clk_i) begin
    hold <= hold + 1;
    connect_o <= start_i || pulse > 1;
    if (start_i) begin
      pulse <= 3;
      if (!busy) begin
        bits_o <= 0;
        busy <= 1'b1;
      end
    end else if (pulse > 0) begin
      pulse <= pulse - 1;
    end
    if (bit_strobe_i && busy) begin
      write_data_o <= addr_i[bits_o];
      bits_o <= bits_o + 1;
      hold <= 0;
      if (bits_o == 25) begin
        busy <= 1'b0;
      end
    end else if (hold == 6) begin
      // Hold time over: stale bit must not look valid
      write_data_o <= ~write_data_o;
    end
  end
endmodule

// ---- dasi_top_tb.sv ----
// Purpose: self-checking bench for the disc address intake block
// Assumes: host model drives connect and the serial address
// Notes: expected values come from the field packing model
`timescale 1ns/10ps
module dasi_top_tb;
  import dasi_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic start = 1'b0;
  logic [25:0] addr = '0;
  logic conf = 1'b0, held = 1'b0, cnfd = 1'b0, near = 1'b0;
  logic hend = 1'b0, rend = 1'b0, pre = 1'b0, stop = 1'b0;
  logic connect, wdata, strobe, acc, busy, vfy, appr, chel, hdone, rdone, sst;
  logic wrong, perr, impr, fa_o, fh_o;
  logic [7:0] sect;
  logic [2:0] head;
  logic [5:0] pos_o;
  logic [4:0] disc_o;
  logic [3:0] chan_o;
  dasi_state_type state;
  int bits;
  int errors = 0;
  int checks_done = 0;
  int starts = 0;
  logic [31:0] lfsr = 32'h4D5DE69E;
  always #5 ref_clk_i = ~ref_clk_i;
  // Seek start stands one cycle: count it at the falling edge
  always @(negedge ref_clk_i) begin
    if (sst === 1'b1) begin
      starts++;
    end
  end
  dasi_host_model i_host (.clk_i(ref_clk_i), .start_i(start), .addr_i(addr),
    .bit_strobe_i(strobe), .connect_o(connect), .write_data_o(wdata), .bits_o(bits));
  dasi_top i_dut (.ref_clk_i, .sys_rst_i, .connect_i(connect), .write_data_i(wdata),
    .area_conflict_i(conf), .held_elsewhere_i(held), .track_confirmed_i(cnfd),
    .sector_before_i(near), .header_end_i(hend), .record_end_i(rend), .prelude_i(pre),
    .stop_i(stop), .bit_strobe_o(strobe), .seek_accepted_o(acc), .area_conflict_o(busy),
    .track_verified_o(vfy), .sector_approach_o(appr), .channel_held_o(chel),
    .header_area_done_o(hdone), .record_area_done_o(rdone), .wrong_command_o(wrong),
    .parity_error_o(perr), .improper_address_o(impr), .seek_start_o(sst),
    .first_avail_o(fa_o), .fixed_head_o(fh_o), .head_sel_o(head), .sector_o(sect),
    .position_o(pos_o), .disc_o(disc_o), .channel_o(chan_o), .state_o(state));
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Fields in wire order, odd parity on top
  function automatic logic [25:0] pack(input int fa, fh, rec, pos, disc, chan, bad);
    logic [24:0] a;
    a = {chan[3:0], disc[4:0], pos[5:0], rec[7:0], fh[0], fa[0]};
    return {~^a ^ bad[0], a};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic send(input logic [25:0] a, input bit dup);
    addr = a;
    start = 1'b1;
    @(negedge ref_clk_i);
    start = 1'b0;
    if (dup) begin
      repeat (9) @(negedge ref_clk_i);
      start = 1'b1;
      @(negedge ref_clk_i);
      start = 1'b0;
    end
    repeat (2000) if (bits < 26) @(negedge ref_clk_i);
    check("bit count", bits, 26);
    repeat (12) @(negedge ref_clk_i);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    end_sim();
  end
  initial begin
    int fa, fh, pos, rec, n0;
    repeat (16) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 10; i++) begin
      lfsr = next_rand(lfsr);
      fa = i == 1;
      fh = i == 2 || i == 3;
      pos = fh ? 9 + i : lfsr[5:0];
      conf = i == 5;
      held = i == 6;
      cnfd = i == 7;
      rec = lfsr[13:6];
      n0 = starts;
      send(pack(fa, fh, rec, pos, lfsr[18:14], lfsr[22:19], i == 4), i == 8);
      check("seek start", starts - n0, i != 3 && i != 4);
      check("accepted", acc, i < 3 || i > 6);
      check("conflict", busy, i == 5);
      check("held", chel, i == 6);
      check("parity", perr, i == 4);
      check("improper", impr, i == 3);
      check("wrong cmd", wrong, i == 8);
      check("verified", vfy, i == 7);
      if (i != 3 && i != 4) begin
        check("first avail", fa_o, fa[0]);
        check("fixed head", fh_o, fh[0]);
        check("position", pos_o, pos[5:0]);
        check("disc", disc_o, lfsr[18:14]);
        check("channel", chan_o, lfsr[22:19]);
        // Default head order alternates outer and inner heads
        check("head", head, (rec % 2) * 4 + (rec / 2) % 4);
        check("sector", sect, fa ? 0 : rec / 8);
      end
      if (i == 5) begin
        conf = 1'b0;
        repeat (20) if (acc !== 1'b1) @(negedge ref_clk_i);
        check("released", acc, 1'b1);
      end
      if (i == 7) begin
        near = 1'b1;
        repeat (20) if (appr !== 1'b1) @(negedge ref_clk_i);
        check("approach", appr, 1'b1);
        pre = 1'b1;
        @(negedge ref_clk_i);
        pre = 1'b0;
        hend = 1'b1;
        repeat (20) if (hdone !== 1'b1) @(negedge ref_clk_i);
        check("header done", hdone, 1'b1);
        hend = 1'b0;
        rend = 1'b1;
        repeat (20) if (rdone !== 1'b1) @(negedge ref_clk_i);
        check("record done", rdone, 1'b1);
        rend = 1'b0;
        stop = 1'b1;
        @(negedge ref_clk_i);
        stop = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        check("window stop", state, ST_VERIFIED);
        near = 1'b0;
      end
    end
    end_sim();
  end
endmodule
